//--- design/itm_timer.sv
// What this block does
// - Mode 2 output high, low for one pulse at count 1, reload, period N.
// - Mode 2 gate low stops counting; gate falling during low pulse forces output high.
// - Mode 2 gate rising reloads count next pulse; low pulse N pulses later.
// - Mode 2 count write loads next pulse; low pulse N pulses after write.
// - Mode 2 new count waits for period end, or loads after a trigger.
// - Mode 3 output high for first half of count, low for remainder, period N.
// - Mode 3 gate low halts, falling gate forces high, rising gate reloads.
// - Mode 3 new count loads after trigger, else at end of half-cycle.
// - Mode 3 even count loads N, subtracts two, at 2 toggles and reloads.
// - Mode 3 odd count loads N-1, low one pulse late, high on next expiry.
// - Mode 4 output high; count write starts; one-pulse low strobe at expiry.
// - Mode 4 gate only enables counting; strobe N+1 pulses after write.
// - Mode 4 new count loads next pulse; only the high byte triggers loading.
// - Mode 5 gate rising loads count next pulse; strobe N+1 pulses after.
// - Mode 5 every trigger reloads; new count waits for the next trigger.
// - Gate sampled on timer clock rise as level and via cleared edge flip-flop.
// - Loads and decrements happen on the falling edge of the timer clock.
// - Count zero means 65536 binary or 10000 decimal.
// - Modes 4 and 5 wrap past zero; modes 2 and 3 reload.
// - Gate comes from a control bit that resets low.
// - A mode write resets control logic at once and sets the output level.
// - A timer clock pulse is a rise then a fall; gate sampled on the rise.
// Holds the timer channel with its AXI4-Lite register slave.
// Assumes a single AXI master with at most one write and one read in flight.
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
module itm_timer
   import itm_pkg::*;
(
   input  wire logic                    MCLK,
   input  wire logic                    NRST,
   input  wire logic                    TIMER_COUNT_CLOCK,
   output logic                        TIMER_PIN_LEVEL,
   input  wire logic [itm_pkg::ITM_AW-1:0] AWADDR,
   input  wire logic                    AWVALID,
   output logic                        AWREADY,
   input  wire logic [itm_pkg::ITM_DW-1:0] WDATA,
   input  wire logic [3:0]              WSTRB,
   input  wire logic                    WVALID,
   output logic                        WREADY,
   output logic [1:0]                  BRESP,
   output logic                        BVALID,
   input  wire logic                    BREADY,
   input  wire logic [itm_pkg::ITM_AW-1:0] ARADDR,
   input  wire logic                    ARVALID,
   output logic                        ARREADY,
   output logic [itm_pkg::ITM_DW-1:0]  RDATA,
   output logic [1:0]                  RRESP,
   output logic                        RVALID,
   input  wire logic                    RREADY
);
   import itm_pkg::*;

   // One decrement step, binary or digit-wise decimal; zero wraps to the top.
   function automatic logic [15:0] itm_dec(input logic [15:0] v, input logic bcd);
      logic [15:0] r;
      logic        br;
      r  = v - ITM_CNT_ONE;
      br = 1'b1;
      if (bcd)
      begin
         for (int i = 0; i < 4; i++)
         begin
            r[4*i +: 4] = v[4*i +: 4];
            if (br)
            begin
               if (v[4*i +: 4] == 4'h0)
               begin
                  r[4*i +: 4] = 4'h9;
               end
               else
               begin
                  r[4*i +: 4] = v[4*i +: 4] - 4'h1;
                  br          = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   logic        tclk_rise;
   logic        tclk_fall;
   logic        awready_reg;
   logic        wready_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        arready_reg;
   logic        rvalid_reg;
   logic [1:0]  rresp_reg;
   logic [31:0] rdata_reg;
   logic [7:0]  awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        do_wr;
   logic        wr_ctrl;
   logic        wr_cnt_hi;
   itm_ctrl_t   ctrl_reg;
   logic [15:0] cr_reg;
   logic        gate_reg;
   logic        gate_d_reg;
   logic        edge_ff_reg;
   logic        gate_smp_reg;
   logic        edge_smp_reg;
   logic [15:0] ce_reg;
   logic        out_reg;
   logic        loaded_reg;
   logic        load_req_reg;
   logic        armed_reg;
   logic        ext_reg;
   logic [15:0] ce_dec;
   logic [15:0] ce_dec2;
   logic [15:0] ld3_val;
   logic        periodic;
   logic        trig_mode;

   itm_tclk_sync u_sync
   (
      .clk   (MCLK),
      .rst_n (NRST),
      .pin   (TIMER_COUNT_CLOCK),
      .rise  (tclk_rise),
      .fall  (tclk_fall)
   );

   // Write address and data are taken independently; the write acts once both are held.
   always_ff @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
      begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= ITM_RESP_OKAY;
         awaddr_q    <= 8'h00;
         wdata_q     <= 32'h0000_0000;
         wstrb_q     <= 4'h0;
      end
      else
      begin
         if (AWVALID && awready_reg)
         begin
            awready_reg <= 1'b0;
            awaddr_q    <= AWADDR;
         end
         if (WVALID && wready_reg)
         begin
            wready_reg <= 1'b0;
            wdata_q    <= WDATA;
            wstrb_q    <= WSTRB;
         end
         if (do_wr)
         begin
            bvalid_reg <= 1'b1;
            if (awaddr_q == ITM_OFS_CTRL || awaddr_q == ITM_OFS_COUNT ||
                awaddr_q == ITM_OFS_GATE || awaddr_q == ITM_OFS_STATUS)
            begin
               bresp_reg <= ITM_RESP_OKAY;
            end
            else
            begin
               bresp_reg <= ITM_RESP_SLVERR;
            end
         end
         else if (bvalid_reg && BREADY)
         begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
      end
   end

   assign do_wr     = !awready_reg && !wready_reg && !bvalid_reg;
   assign wr_ctrl   = do_wr && awaddr_q == ITM_OFS_CTRL && wstrb_q[0];
   assign wr_cnt_hi = do_wr && awaddr_q == ITM_OFS_COUNT && wstrb_q[1];

   // Read answers one cycle after the address is taken.
   always_ff @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
      begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rresp_reg   <= ITM_RESP_OKAY;
         rdata_reg   <= 32'h0000_0000;
      end
      else if (ARVALID && arready_reg)
      begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rresp_reg   <= ITM_RESP_OKAY;
         rdata_reg   <= 32'h0000_0000;
         if (ARADDR == ITM_OFS_CTRL)
         begin
            rdata_reg[3:0] <= ctrl_reg;
         end
         else if (ARADDR == ITM_OFS_COUNT)
         begin
            rdata_reg[15:0] <= cr_reg;
         end
         else if (ARADDR == ITM_OFS_GATE)
         begin
            rdata_reg[ITM_GATE_BIT] <= gate_reg;
         end
         else if (ARADDR == ITM_OFS_STATUS)
         begin
            rdata_reg[15:0]          <= ce_reg;
            rdata_reg[ITM_ST_OUT]    <= out_reg;
            rdata_reg[ITM_ST_LOADED] <= loaded_reg;
         end
         else
         begin
            rresp_reg <= ITM_RESP_SLVERR;
         end
      end
      else if (rvalid_reg && RREADY)
      begin
         rvalid_reg  <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   // Mode word, count holder and gate bit. A mode write clears the count holder.
   always_ff @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
      begin
         ctrl_reg <= ITM_CTRL_RST;
         cr_reg   <= ITM_COUNT_RST;
         gate_reg <= ITM_GATE_RST;
      end
      else if (do_wr)
      begin
         if (wr_ctrl)
         begin
            ctrl_reg.bcd  <= wdata_q[ITM_CTRL_BCD];
            ctrl_reg.mode <= itm_mode_t'(wdata_q[ITM_CTRL_MODE_LO +: 3]);
            cr_reg        <= ITM_COUNT_RST;
         end
         if (awaddr_q == ITM_OFS_COUNT)
         begin
            if (wstrb_q[0])
            begin
               cr_reg[7:0] <= wdata_q[7:0];
            end
            if (wstrb_q[1])
            begin
               cr_reg[15:8] <= wdata_q[15:8];
            end
         end
         if (awaddr_q == ITM_OFS_GATE && wstrb_q[0])
         begin
            gate_reg <= wdata_q[ITM_GATE_BIT];
         end
      end
   end

   // Gate rising edges are caught at once and held until the next timer clock rise samples them.
   always_ff @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
      begin
         gate_d_reg   <= ITM_GATE_RST;
         edge_ff_reg  <= 1'b0;
         gate_smp_reg <= 1'b0;
         edge_smp_reg <= 1'b0;
      end
      else
      begin
         gate_d_reg <= gate_reg;
         if (tclk_rise)
         begin
            gate_smp_reg <= gate_reg;
            edge_smp_reg <= edge_ff_reg;
         end
         edge_ff_reg <= (edge_ff_reg && !tclk_rise) || (gate_reg && !gate_d_reg);
      end
   end

   assign ce_dec    = itm_dec(ce_reg, ctrl_reg.bcd);
   assign ce_dec2   = itm_dec(ce_dec, ctrl_reg.bcd);
   assign ld3_val   = cr_reg[0] ? itm_dec(cr_reg, ctrl_reg.bcd) : cr_reg;
   assign periodic  = ctrl_reg.mode == ITM_M2 || ctrl_reg.mode == ITM_M3;
   assign trig_mode = periodic || ctrl_reg.mode == ITM_M5;

   // Count element and output. Zero in the holder counts as the full range,
   // since the decrement wraps it to the top value.
   always_ff @(posedge MCLK or negedge NRST)
   begin
      if (!NRST)
      begin
         ce_reg       <= ITM_COUNT_RST;
         out_reg      <= ITM_OUT_RST;
         loaded_reg   <= 1'b0;
         load_req_reg <= 1'b0;
         armed_reg    <= 1'b0;
         ext_reg      <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         out_reg      <= ITM_OUT_RST;
         loaded_reg   <= 1'b0;
         load_req_reg <= 1'b0;
         armed_reg    <= 1'b0;
         ext_reg      <= 1'b0;
      end
      else
      begin
         if (tclk_fall)
         begin
            if ((load_req_reg && ctrl_reg.mode != ITM_M5) || (edge_smp_reg && trig_mode))
            begin
               // The loading pulse never decrements.
               ce_reg       <= (ctrl_reg.mode == ITM_M3) ? ld3_val : cr_reg;
               out_reg      <= 1'b1;
               loaded_reg   <= 1'b1;
               load_req_reg <= 1'b0;
               armed_reg    <= 1'b1;
               ext_reg      <= 1'b0;
            end
            else if (loaded_reg)
            begin
               case (ctrl_reg.mode)
                  ITM_M2:
                  begin
                     if (gate_smp_reg)
                     begin
                        if (ce_reg == ITM_CNT_ONE)
                        begin
                           ce_reg  <= cr_reg;
                           out_reg <= 1'b1;
                        end
                        else
                        begin
                           ce_reg  <= ce_dec;
                           out_reg <= ce_reg != ITM_CNT_TWO;
                        end
                     end
                  end
                  ITM_M3:
                  begin
                     if (gate_smp_reg)
                     begin
                        if (ext_reg)
                        begin
                           out_reg <= 1'b0;
                           ce_reg  <= ld3_val;
                           ext_reg <= 1'b0;
                        end
                        else if (ce_reg == ITM_CNT_TWO)
                        begin
                           if (out_reg && cr_reg[0])
                           begin
                              ext_reg <= 1'b1;
                           end
                           else
                           begin
                              out_reg <= !out_reg;
                              ce_reg  <= ld3_val;
                           end
                        end
                        else
                        begin
                           ce_reg <= ce_dec2;
                        end
                     end
                  end
                  ITM_M4, ITM_M5:
                  begin
                     if (gate_smp_reg || ctrl_reg.mode == ITM_M5)
                     begin
                        ce_reg <= ce_dec;
                        if (armed_reg && ce_reg == ITM_CNT_ONE)
                        begin
                           out_reg   <= 1'b0;
                           armed_reg <= 1'b0;
                        end
                        else
                        begin
                           out_reg <= 1'b1;
                        end
                     end
                     else
                     begin
                        out_reg <= 1'b1;
                     end
                  end
                  default:
                  begin
                     out_reg <= 1'b1;
                  end
               endcase
            end
         end
         // Standalone so a gate fall landing on a timer fall still forces the output high.
         if (periodic && gate_d_reg && !gate_reg && !out_reg)
         begin
            out_reg <= 1'b1;
         end
         // A count write arriving with a load in the same cycle still wins.
         if (wr_cnt_hi && (ctrl_reg.mode == ITM_M4 || (periodic && !loaded_reg)))
         begin
            load_req_reg <= 1'b1;
         end
      end
   end

   assign TIMER_PIN_LEVEL = out_reg;
   assign AWREADY         = awready_reg;
   assign WREADY          = wready_reg;
   assign BVALID          = bvalid_reg;
   assign BRESP           = bresp_reg;
   assign ARREADY         = arready_reg;
   assign RVALID          = rvalid_reg;
   assign RRESP           = rresp_reg;
   assign RDATA           = rdata_reg;

   property p_mode_reset;
      @(posedge MCLK) disable iff (!NRST)
      wr_ctrl |=> out_reg && !loaded_reg && !load_req_reg;
   endproperty
   a_mode_reset: assert property (p_mode_reset) else $error("mode write did not reset");

   property p_m2_low;
      @(posedge MCLK) disable iff (!NRST)
      (ctrl_reg.mode == ITM_M2 && tclk_fall && loaded_reg && gate_smp_reg && !wr_ctrl &&
       !load_req_reg && !edge_smp_reg && ce_reg == ITM_CNT_TWO) |=> !out_reg && ce_reg == 16'h0001;
   endproperty
   a_m2_low: assert property (p_m2_low) else $error("mode 2 pulse missing at count one");

   property p_gate_fall;
      @(posedge MCLK) disable iff (!NRST)
      (periodic && $fell(gate_reg) && !out_reg && !wr_ctrl) |=> ##[0:1] out_reg;
   endproperty
   a_gate_fall: assert property (p_gate_fall) else $error("output not forced high");

   property p_edge_set;
      @(posedge MCLK) disable iff (!NRST)
      $rose(gate_reg) |=> edge_ff_reg;
   endproperty
   a_edge_set: assert property (p_edge_set) else $error("gate edge not caught");

   property p_fall_only;
      @(posedge MCLK) disable iff (!NRST)
      (!tclk_fall && !wr_ctrl) |=> $stable(ce_reg);
   endproperty
   a_fall_only: assert property (p_fall_only) else $error("count moved off a fall");

   property p_m4_req;
      @(posedge MCLK) disable iff (!NRST)
      (wr_cnt_hi && ctrl_reg.mode == ITM_M4 && !wr_ctrl) |=> load_req_reg;
   endproperty
   a_m4_req: assert property (p_m4_req) else $error("mode 4 load not requested");

   property p_m4_hold;
      @(posedge MCLK) disable iff (!NRST)
      (ctrl_reg.mode == ITM_M4 && tclk_fall && !gate_smp_reg && !load_req_reg && !wr_ctrl)
      |=> $stable(ce_reg) && out_reg;
   endproperty
   a_m4_hold: assert property (p_m4_hold) else $error("mode 4 counted with gate low");

   property p_m5_load;
      @(posedge MCLK) disable iff (!NRST)
      (ctrl_reg.mode == ITM_M5 && tclk_fall && edge_smp_reg && !wr_ctrl)
      |=> ce_reg == $past(cr_reg) && out_reg && armed_reg;
   endproperty
   a_m5_load: assert property (p_m5_load) else $error("mode 5 trigger did not load");
endmodule

//--- design/itm_pkg.sv
// Shared constants and types of the interval timer channel (modes 2 to 5).
// Assumes one system clock; the timer count clock arrives as a plain pin.
package itm_pkg;

   localparam int          ITM_AW           = 8;
   localparam int          ITM_DW           = 32;

   // Register byte offsets on the AXI4-Lite bus.
   localparam logic [7:0]  ITM_OFS_CTRL     = 8'h00;
   localparam logic [7:0]  ITM_OFS_COUNT    = 8'h04;
   localparam logic [7:0]  ITM_OFS_GATE     = 8'h08;
   localparam logic [7:0]  ITM_OFS_STATUS   = 8'h0c;

   // Field positions.
   localparam int          ITM_CTRL_BCD     = 0;
   localparam int          ITM_CTRL_MODE_LO = 1;
   localparam int          ITM_GATE_BIT     = 0;
   localparam int          ITM_ST_OUT       = 16;
   localparam int          ITM_ST_LOADED    = 17;

   // Reset values.
   localparam logic        ITM_GATE_RST     = 1'b0;
   localparam logic        ITM_OUT_RST      = 1'b1;
   localparam logic [15:0] ITM_COUNT_RST    = 16'h0000;

   // AXI response codes.
   localparam logic [1:0]  ITM_RESP_OKAY    = 2'h0;
   localparam logic [1:0]  ITM_RESP_SLVERR  = 2'h2;

   // Count values with a meaning in the sequences.
   localparam logic [15:0] ITM_CNT_ONE      = 16'h0001;
   localparam logic [15:0] ITM_CNT_TWO      = 16'h0002;

   typedef enum logic [2:0] {
      ITM_M0, ITM_M1, ITM_M2, ITM_M3, ITM_M4, ITM_M5, ITM_M6, ITM_M7
   } itm_mode_t;

   typedef struct packed {
      itm_mode_t mode;
      logic      bcd;
   } itm_ctrl_t;

   localparam itm_ctrl_t   ITM_CTRL_RST     = '{mode: ITM_M0, bcd: 1'b0};

endpackage

//--- design/itm_tclk_sync.sv
// Two-stage synchroniser and edge finder for the timer count clock pin.
// Assumes the pin is asynchronous to clk and far slower than it.
`timescale 1ns/100ps
module itm_tclk_sync
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic pin,
   output logic      rise,
   output logic      fall
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // Only the second and third stages are compared, never the first.
   assign rise = s2_reg & ~s3_reg;
   assign fall = ~s2_reg & s3_reg;
endmodule

//--- tb/itm_clk_src.sv
// Behavioural timer count clock source that makes one pulse per start strobe.
// Assumes start is a one-cycle strobe on clk and the pin rests low between pulses.
`timescale 1ns/100ps
module itm_clk_src
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,
   output logic      tclk,
   output logic      busy
);
   logic [3:0] phase_reg;

   // Each level lasts at least four cycles so the pin synchroniser never misses one.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         phase_reg <= 4'h0;
      else if (phase_reg != 4'h0)
         phase_reg <= (phase_reg == 4'ha) ? 4'h0 : phase_reg + 4'h1;
      else if (start)
         phase_reg <= 4'h1;
   end

   // A pulse is a rise followed by a fall.
   assign tclk = (phase_reg >= 4'h1) && (phase_reg <= 4'h4);
   assign busy = (phase_reg != 4'h0);
endmodule

//--- tb/test_itm_timer.sv
// Self-checking bench for the interval timer channel in modes 2 to 5.
// Assumes the register map of itm_pkg and a pulse-by-pulse timer clock source.
`timescale 1ns/100ps
module test_itm_timer;
   import itm_pkg::*;
   logic        mclk;
   logic        nrst;
   logic        tstart;
   logic        tclk;
   logic        tbusy;
   logic        pin;
   logic [7:0]  awaddr;
   logic [7:0]  araddr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic [31:0] rd_d;
   logic [3:0]  wstrb;
   logic        awvalid;
   logic        awready;
   logic        wvalid;
   logic        wready;
   logic        bvalid;
   logic        bready;
   logic        arvalid;
   logic        arready;
   logic        rvalid;
   logic        rready;
   logic [1:0]  bresp;
   logic [1:0]  rresp;
   logic [1:0]  rs;
   int          err_total;
   int          num_checks;
   int          cyc;
   int          lows;

   itm_clk_src u_src (.clk(mclk), .rst_n(nrst), .start(tstart), .tclk(tclk), .busy(tbusy));

   itm_timer u_dut
   (
      .MCLK              (mclk),
      .NRST              (nrst),
      .TIMER_COUNT_CLOCK (tclk),
      .TIMER_PIN_LEVEL   (pin),
      .AWADDR            (awaddr),
      .AWVALID           (awvalid),
      .AWREADY           (awready),
      .WDATA             (wdata),
      .WSTRB             (wstrb),
      .WVALID            (wvalid),
      .WREADY            (wready),
      .BRESP             (bresp),
      .BVALID            (bvalid),
      .BREADY            (bready),
      .ARADDR            (araddr),
      .ARVALID           (arvalid),
      .ARREADY           (arready),
      .RDATA             (rdata),
      .RRESP             (rresp),
      .RVALID            (rvalid),
      .RREADY            (rready)
   );

   task results;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // The extra edge at the end keeps two tasks from driving one signal in one step.
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
      @(posedge mclk);
   endtask

   task rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge mclk);
         if (arready)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      rd_d = rdata;
      rs = rresp;
      rready <= 1'b0;
      @(posedge mclk);
   endtask

   // Bit k of m set means the pin is expected low after pulse k+1.
   task pulses(input int n, input logic [15:0] m, input bit en);
      for (int k = 0; k < n; k++)
      begin
         tstart <= 1'b1;
         @(posedge mclk);
         tstart <= 1'b0;
         do
            @(posedge mclk);
         while (tbusy);
         if (pin === 1'b0)
            lows++;
         if (en)
            chk("pin", {31'h0, ~m[k]}, {31'h0, pin});
      end
   endtask

   task cfg(input logic [31:0] md, input logic [31:0] cnt);
      wr(ITM_OFS_CTRL, md, 4'h1);
      chk("pin after mode write", 32'h1, {31'h0, pin});
      wr(ITM_OFS_COUNT, cnt, 4'h3);
   endtask

   task t_reset;
      rd(ITM_OFS_CTRL);
      chk("ctrl", 32'h0, rd_d);
      rd(ITM_OFS_COUNT);
      chk("count", 32'h0, rd_d);
      rd(ITM_OFS_GATE);
      chk("gate", 32'h0, rd_d);
      rd(ITM_OFS_STATUS);
      chk("status", 32'h1 << ITM_ST_OUT, rd_d);
      rd(8'h20);
      chk("unmapped rresp", {30'h0, ITM_RESP_SLVERR}, {30'h0, rs});
      wr(8'h20, 32'h5, 4'hf);
      chk("unmapped bresp", {30'h0, ITM_RESP_SLVERR}, {30'h0, rs});
   endtask

   task t_mode2;
      wr(ITM_OFS_GATE, 32'h1, 4'h1);
      cfg(32'h4, 32'h3);
      pulses(6, 16'b100100, 1'b1);
      wr(ITM_OFS_GATE, 32'h0, 4'h1);
      chk("pin on gate fall", 32'h1, {31'h0, pin});
      pulses(2, 16'h0, 1'b1);
      wr(ITM_OFS_GATE, 32'h1, 4'h1);
      pulses(3, 16'b100, 1'b1);
   endtask

   task t_mode3(input logic [31:0] n, input int exp_lows);
      cfg(32'h6, n);
      pulses(1, 16'h0, 1'b0);
      lows = 0;
      pulses(2 * int'(n), 16'h0, 1'b0);
      chk("square wave low pulses", 32'(exp_lows), 32'(lows));
   endtask

   task t_mode4;
      cfg(32'h8, 32'h2);
      pulses(6, 16'b000100, 1'b1);
      wr(ITM_OFS_COUNT, 32'h5, 4'h1);
      wr(ITM_OFS_GATE, 32'h0, 4'h1);
      pulses(2, 16'h0, 1'b1);
      rd(ITM_OFS_STATUS);
      chk("count after wrap and hold", 32'h0003_fffd, rd_d);
   endtask

   task t_mode5;
      wr(ITM_OFS_GATE, 32'h0, 4'h1);
      cfg(32'ha, 32'h2);
      pulses(3, 16'h0, 1'b1);
      wr(ITM_OFS_GATE, 32'h1, 4'h1);
      pulses(4, 16'b0100, 1'b1);
      wr(ITM_OFS_GATE, 32'h0, 4'h1);
      wr(ITM_OFS_GATE, 32'h1, 4'h1);
      pulses(4, 16'b0100, 1'b1);
   endtask

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // Every scenario fits in a few hundred cycles, so this ceiling only cuts hangs.
   initial
   begin
      cyc = 0;
      forever
      begin
         @(posedge mclk);
         cyc++;
         if (cyc == 40000)
         begin
            err_total++;
            results;
         end
      end
   end

   initial
   begin
      err_total = 0;
      num_checks = 0;
      lows = 0;
      nrst = 1'b0;
      tstart = 1'b0;
      awaddr = 8'h0;
      araddr = 8'h0;
      wdata = 32'h0;
      wstrb = 4'h0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      repeat (16) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      chk("pin after reset", 32'h1, {31'h0, pin});
      t_reset;
      t_mode2;
      t_mode3(32'h4, 4);
      t_mode3(32'h5, 4);
      t_mode4;
      t_mode5;
      results;
   end
endmodule
